// ===== src/irxm_pkg.sv
/*
 * Package for the upper isochronous receive channel mask block.
 * Holds register offsets, widths and AHB-Lite encodings.
 * Assumes a single AHB-Lite slave with 32-bit data.
 */
package irxm_pkg;
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned CHAN_BASE    = 32;
    // Channel number split: top bit picks the upper group, the rest index the mask
    localparam int unsigned CHAN_IDX_W     = 5;
    localparam int unsigned CHAN_UPPER_BIT = 5;
    // ========================================
    // Register map
    localparam logic [7:0]  OFF_MASK_SET = 8'h70;
    localparam logic [7:0]  OFF_MASK_CLR = 8'h74;
    localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
    localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;
    // ========================================
    // AHB-Lite encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
    localparam logic        HRESP_OKAY    = 1'h0;
    localparam logic [5:0]  CHAN_W        = 6'h3F;
endpackage : irxm_pkg

// ===== src/irxm_mask_high.sv
/*
 * Upper isochronous receive channel mask (channels 32..63) as an AHB-Lite slave,
 * plus the packet accept/discard gate that applies it.
 * Assumes hready and the packet qualifier are synchronous to i_clk.
 */
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps

module irxm_mask_high
    import irxm_pkg::*;
(
    input  wire logic                         i_clk,        // 100 MHz clock
    input  wire logic                         i_rst,        // Sync reset, high
    input  wire logic                         i_hsel,       // Slave select
    input  wire logic [irxm_pkg::ADDR_W-1:0]  i_haddr,      // Byte address
    input  wire logic [1:0]                   i_htrans,     // Transfer type
    input  wire logic                         i_hwrite,     // Write when high
    input  wire logic [2:0]                   i_hsize,      // Transfer size
    input  wire logic [irxm_pkg::DATA_W-1:0]  i_hwdata,     // Write data
    input  wire logic                         i_hready,     // Bus ready in
    output logic      [irxm_pkg::DATA_W-1:0]  o_hrdata,     // Read data
    output logic                              o_hreadyout,  // Always ready
    output logic                              o_hresp,      // Always OKAY
    input  wire logic                         i_pkt_valid,  // Iso packet header strobe
    input  wire logic [5:0]                   i_pkt_chan,   // Packet channel 0..63
    output logic                              o_pkt_accept, // Upper packet passes
    output logic                              o_pkt_discard,// Upper packet dropped
    output logic      [irxm_pkg::DATA_W-1:0]  o_chan_enable // Enable vector, ch 32..63
);
    import irxm_pkg::*;

    // ========================================
    // Usage notes
    // Two addresses reach one mask: ones at the set address raise bits,
    // ones at the clear address drop them, zeros leave bits alone.
    // A read of either address returns the mask and changes nothing.
    // Limitation: hsize is not checked, every access is taken as a word.
    // Limitation: unmapped addresses answer OKAY; reads give zero.
    // The receive gate only judges channels 32..63; the lower group
    // belongs to another block and gets neither pulse here.

    // ========================================
    // Declarations
    // Address phase decode
    logic                  phase_ok;
    logic                  hit_set;
    logic                  hit_clr;
    logic                  rd_req;

    // Data phase flags; at most one transfer is in its data phase
    logic                  wr_set_r;
    logic                  wr_set_nxt;
    logic                  wr_clr_r;
    logic                  wr_clr_nxt;

    // Stored mask and the per-bit strobes that change it
    logic [DATA_W-1:0]     mask_r;
    logic [DATA_W-1:0]     mask_nxt;
    logic [DATA_W-1:0]     bit_set;
    logic [DATA_W-1:0]     bit_clr;

    // Read data, held through the data phase
    logic [DATA_W-1:0]     rdata_r;
    logic [DATA_W-1:0]     rdata_nxt;

    // Receive gate
    logic                  upper;
    logic [CHAN_IDX_W-1:0] chan_idx;
    logic                  chan_on;
    logic                  acc_r;
    logic                  acc_nxt;
    logic                  dis_r;
    logic                  dis_nxt;

    // ========================================
    // Address match
    always_comb begin
        hit_set = (i_haddr == OFF_MASK_SET);
        hit_clr = (i_haddr == OFF_MASK_CLR);
    end

    // ========================================
    // Transfer qualify
    // Only NONSEQ and SEQ start a transfer; IDLE and BUSY are ignored
    always_comb begin
        phase_ok   = i_hsel && i_hready && ((i_htrans == HTRANS_NONSEQ) || (i_htrans == HTRANS_SEQ));
        wr_set_nxt = phase_ok && i_hwrite && hit_set;
        wr_clr_nxt = phase_ok && i_hwrite && hit_clr;
        // Unmapped reads fall through and return zero
        rd_req     = phase_ok && !i_hwrite && (hit_set || hit_clr);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_set_r <= 1'b0;
            wr_clr_r <= 1'b0;
        end else begin
            wr_set_r <= wr_set_nxt;
            wr_clr_r <= wr_clr_nxt;
        end
    end

    // ========================================
    // Per-bit write strobes
    // Write data is looked at only in a data phase, so stray hwdata
    // between transfers never reaches the mask
    always_comb begin
        bit_set = '0;
        bit_clr = '0;
        if (wr_set_r) begin
            bit_set = i_hwdata;
        end
        if (wr_clr_r) begin
            bit_clr = i_hwdata;
        end
    end

    // ========================================
    // Mask bits, one slice per upper channel
    // Bit n enables channel n plus 32; the slices share nothing
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_mask_bit
            always_comb begin
                // Set and clear cannot meet: one data phase per cycle
                if (bit_set[gi]) begin
                    mask_nxt[gi] = 1'b1;
                end else if (bit_clr[gi]) begin
                    mask_nxt[gi] = 1'b0;
                end else begin
                    mask_nxt[gi] = mask_r[gi];
                end
            end

            // Reset value is left open on the bus side; zero keeps runs repeatable
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    mask_r[gi] <= MASK_RESET[gi];
                end else begin
                    mask_r[gi] <= mask_nxt[gi];
                end
            end
        end
    endgenerate

    // ========================================
    // Read data
    // Captured at the address phase edge so it stands for the whole data phase.
    // Taking mask_nxt lets a read right behind a write see the new value.
    always_comb begin
        rdata_nxt = RDATA_ZERO;
        if (rd_req) begin
            rdata_nxt = mask_nxt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_r <= RDATA_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ========================================
    // Receive gate, channel lookup
    always_comb begin
        upper    = i_pkt_chan[CHAN_UPPER_BIT];
        chan_idx = i_pkt_chan[CHAN_IDX_W-1:0];
        chan_on  = mask_r[chan_idx];
    end

    // ========================================
    // Receive gate, decision
    // Decision is one cycle behind the header strobe; exactly one pulse
    // for an upper channel, none for a lower one
    always_comb begin
        acc_nxt = 1'b0;
        dis_nxt = 1'b0;
        if (i_pkt_valid && upper) begin
            acc_nxt = chan_on;
            dis_nxt = !chan_on;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            acc_r <= 1'b0;
            dis_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            dis_r <= dis_nxt;
        end
    end

    // ========================================
    // Bus outputs
    // Zero wait states and no error response: every access completes at once
    assign o_hreadyout   = 1'b1;
    assign o_hresp       = HRESP_OKAY;
    assign o_hrdata      = rdata_r;

    // ========================================
    // Receive side outputs
    assign o_chan_enable = mask_r;
    assign o_pkt_accept  = acc_r;
    assign o_pkt_discard = dis_r;
endmodule : irxm_mask_high

// ===== tb/irxm_mask_high_sva.sv
/* Checker for irxm_mask_high. Assumes o_hreadyout feeds i_hready. */
`timescale 1ns/1ps
module irxm_mask_high_sva (
    input wire logic        i_clk, i_rst, i_hsel, i_hwrite, i_hready, i_pkt_valid, o_pkt_accept, o_pkt_discard,
    input wire logic [1:0]  i_htrans,
    input wire logic [5:0]  i_pkt_chan,
    input wire logic [7:0]  i_haddr,
    input wire logic [31:0] i_hwdata, o_hrdata, o_chan_enable
);
    logic       dv_r, dw_r;
    logic [7:0] da_r;
    wire        hit = da_r == 8'h70 || da_r == 8'h74;
    // Data phase tracker
    always_ff @(posedge i_clk) begin
        dv_r <= !i_rst && i_hsel && i_hready && i_htrans[1];
        dw_r <= i_hwrite;
        da_r <= i_haddr;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence wr_s; dv_r && dw_r; endsequence
    set_write_a: assert property (wr_s ##0 da_r == 8'h70 |=>
        o_chan_enable == ($past(o_chan_enable) | $past(i_hwdata))) else $error("set write");
    clear_write_a: assert property (wr_s ##0 da_r == 8'h74 |=>
        o_chan_enable == ($past(o_chan_enable) & ~$past(i_hwdata))) else $error("clear write");
    read_back_a: assert property (dv_r && !dw_r && hit |->
        o_hrdata == o_chan_enable ##1 $stable(o_chan_enable)) else $error("read back");
    unmapped_write_a: assert property (wr_s ##0 !hit |=> $stable(o_chan_enable)) else $error("unmapped");
    mask_hold_a: assert property (!(dv_r && dw_r) |=> $stable(o_chan_enable)) else $error("mask hold");
    upper_pkt_a: assert property (i_pkt_valid && i_pkt_chan[5] |=>
        o_pkt_accept == $past(o_chan_enable[i_pkt_chan[4:0]]) && o_pkt_discard != o_pkt_accept) else $error("upper");
    lower_pkt_a: assert property (i_pkt_valid && !i_pkt_chan[5] |=> !o_pkt_accept && !o_pkt_discard) else $error("lower");
endmodule : irxm_mask_high_sva
bind irxm_mask_high irxm_mask_high_sva u_sva (.*);

// ===== tb/irxm_mask_high_tb_top.sv
/* Testbench for irxm_mask_high. Assumes zero wait states; hready loops back. */
`timescale 1ns/1ps
module irxm_mask_high_tb_top;
    import irxm_pkg::*;
    logic        clk = 0, rst = 1, sel = 0, hw = 0, pv = 0;
    logic [1:0]  tr = 0;
    logic [5:0]  ch = 0;
    logic [7:0]  ad = 0, wa[5] = '{8'h70, 8'h74, 8'h70, 8'h78, 8'h74}, ra[5] = '{8'h74, 8'h70, 8'h74, 8'h78, 8'h70};
    logic [31:0] wd = 0, rd, m = 0, dt[5] = '{32'hA5A5_0F0F, 32'h8000_0001, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0F0F_F0F0};
    wire  [31:0] hr, en;
    wire         rdy, ok, acc, dis;
    int          n_mismatch = 0, checks_done = 0, cyc = 0;
    irxm_mask_high u_dut (.i_clk(clk), .i_rst(rst), .i_hsel(sel), .i_haddr(ad), .i_htrans(tr), .i_hwrite(hw),
        .i_hsize(HSIZE_WORD), .i_hwdata(wd), .i_hready(rdy), .o_hrdata(hr), .o_hreadyout(rdy), .o_hresp(ok),
        .i_pkt_valid(pv), .i_pkt_chan(ch), .o_pkt_accept(acc), .o_pkt_discard(dis), .o_chan_enable(en));
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (++cyc == 2000) begin n_mismatch++; report_and_stop(); end
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin n_mismatch++; $display("MISMATCH t=%0t got %h want %h", $time, s, e); end
    endtask : chk
    // Single AHB-Lite word transfer, waits on hready in both phases
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        tr <= HTRANS_NONSEQ; hw <= w; ad <= a;
        do @(posedge clk); while (rdy !== 1'b1);
        tr <= 2'h0; wd <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = hr;
        chk(ok, HRESP_OKAY);
        chk(rdy, 1'b1);
    endtask : bus
    task t_regs;
        for (int i = 0; i < 5; i++) begin
            bus(1, wa[i], dt[i]);
            m = wa[i] == OFF_MASK_SET ? m | dt[i] : wa[i] == OFF_MASK_CLR ? m & ~dt[i] : m;
            bus(0, ra[i], 0);
            chk(rd, (ra[i] == OFF_MASK_SET || ra[i] == OFF_MASK_CLR) ? m : 0);
            chk(en, m);
        end
        $display("register test done");
    endtask : t_regs
    task t_pkt;
        for (int c = 30; c < 64; c++) begin
            ch <= c[5:0]; pv <= 1;
            @(posedge clk); pv <= 0;
            @(posedge clk);
            chk(acc, c > 31 && m[c[4:0]]);
            chk(dis, c > 31 && !m[c[4:0]]);
        end
        $display("packet test done");
    endtask : t_pkt
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0; sel <= 1;
        @(posedge clk);
        chk(en, MASK_RESET);
        t_regs;
        t_pkt;
        report_and_stop;
    end
endmodule : irxm_mask_high_tb_top
